// ### bench/pmc_cpu_model.sv
/*
  Behavioural CPU core that issues the power instructions as one-cycle strobes.
  Assumes the bench asks for an instruction with a one-cycle go pulse on clk_i.
*/
`timescale 1ns/10ps
module pmc_cpu_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Bench request.
  input wire logic go_i,
  input wire pmc_pkg::pmc_instr_t code_i,
  input wire logic nmi_i,
  input wire logic force_i,
  // Toward the controller.
  output logic instr_valid_o,
  output pmc_pkg::pmc_instr_t instr_o
);
  // --------------------------------------------------------------------
  // Issue
  // --------------------------------------------------------------------
  // Software never sends power-down with the pin high unless forced, so a
  // refusal seen at the block was commanded by the bench on purpose.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      instr_valid_o <= 1'b0;
      instr_o <= pmc_pkg::PMC_INSTR_NONE;
    end else begin
      instr_valid_o <= go_i & ((code_i != pmc_pkg::PMC_INSTR_PDOWN) | ~nmi_i | force_i);
      instr_o <= go_i ? code_i : pmc_pkg::PMC_INSTR_NONE;
    end
  end
endmodule

// ### bench/test_pmc_power_mode_controller.sv
/*
  Self-checking bench of the power mode controller with a CPU model.
  Assumes the design registers every output one edge after its cause.
*/
`timescale 1ns/10ps
module test_pmc_power_mode_controller;
  // --------------------------------------------------------------------
  // Stimulus and observation
  // --------------------------------------------------------------------
  logic clk_i = 1'b0, rst_n_i = 1'b0, go = 1'b0, force_pd = 1'b0, instr_valid;
  pmc_pkg::pmc_instr_t code = pmc_pkg::PMC_INSTR_NONE, instr;
  logic irq = 1'b0, ext = 1'b0, rtc = 1'b0, nmi = 1'b0, keep = 1'b0, div2 = 1'b0;
  logic dis_we = 1'b0, rel_we = 1'b0, run = 1'b0, fo, refd, last;
  logic [15:0] dis = 16'h0000, rel = 16'h0000, busy = 16'hFFFF, pce, pdc;
  pmc_pkg::pmc_state_t st;
  pmc_pkg::pmc_clk_t cc;
  int num_errors = 0, n_checks = 0, k, t;

  initial forever #2 clk_i = ~clk_i;

  pmc_cpu_model cpu_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .go_i(go), .code_i(code),
    .nmi_i(nmi), .force_i(force_pd), .instr_valid_o(instr_valid), .instr_o(instr));

  pmc_power_mode_controller dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .instr_valid_i(instr_valid), .instr_i(instr), .irq_pending_i(irq), .ext_irq_i(ext),
    .rtc_wake_i(rtc), .nmi_pin_i(nmi), .rtc_keep_i(keep), .cpu_div2_i(div2),
    .periph_dis_i(dis), .periph_dis_we_i(dis_we), .freq_reload_i(rel), .freq_we_i(rel_we),
    .freq_run_i(run), .periph_busy_i(busy), .state_o(st), .clk_ctrl_o(cc),
    .periph_clk_en_o(pce), .peripheral_disable_ctrl_o(pdc),
    .programmable_freq_out_o(fo), .pdown_refused_o(refd));

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  task end_of_test;
    if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Compare on four-state values so an unknown never matches.
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Let one edge land, then sample settled outputs.
  task tick;
    @(posedge clk_i);
    #1;
  endtask

  // Model strobes on the next edge; the block takes it one edge later.
  task issue(input pmc_pkg::pmc_instr_t c);
    @(posedge clk_i);
    go <= 1'b1;
    code <= c;
    @(posedge clk_i);
    go <= 1'b0;
    tick();
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    #1;
    chk(16'(st), 16'h0000);
    chk(16'(cc), 16'h000E);
    chk(pdc, 16'h0000);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    dis <= 16'h00A5;
    dis_we <= 1'b1;
    @(posedge clk_i);
    dis_we <= 1'b0;
    tick();
    chk(pdc, 16'h00A5);
    chk(pce, 16'hFF5A);
    // Quiet peripherals must lose their clocks with no software action.
    busy <= 16'h0F0F;
    tick();
    chk(pce, 16'h0F0A);
    chk(16'(st), 16'h0000);
    issue(pmc_pkg::PMC_INSTR_IDLE);
    chk(16'(cc), 16'h0006);
    @(posedge clk_i);
    irq <= 1'b1;
    tick();
    chk(16'(st), 16'h0000);
    irq <= 1'b0;
    issue(pmc_pkg::PMC_INSTR_SLEEP);
    chk(16'(cc), 16'h0000);
    @(posedge clk_i);
    rtc <= 1'b1;
    tick();
    rtc <= 1'b0;
    chk(16'(st), 16'h0003);
    ext <= 1'b1;
    tick();
    chk(16'(cc), 16'h000E);
    ext <= 1'b0;
    keep <= 1'b1;
    issue(pmc_pkg::PMC_INSTR_SLEEP);
    chk(16'(cc), 16'h0002);
    @(posedge clk_i);
    rtc <= 1'b1;
    tick();
    rtc <= 1'b0;
    chk(16'(st), 16'h0000);
    div2 <= 1'b1;
    tick();
    tick();
    chk(16'(cc), 16'h000F);
    rel <= 16'h0002;
    rel_we <= 1'b1;
    run <= 1'b1;
    @(posedge clk_i);
    rel_we <= 1'b0;
    // Half period is reload plus one; wait for two toggles, bounded.
    for (k = 0; k < 2; k++) begin
      last = fo;
      t = 0;
      do begin
        tick();
        t++;
      end while (fo === last && t < 40);
      // A stuck output is a mismatch and ends the run at once.
      if (t >= 40) begin
        num_errors++;
        end_of_test();
      end
    end
    chk(16'(t), 16'h0003);
    run <= 1'b0;
    nmi <= 1'b1;
    force_pd <= 1'b1;
    issue(pmc_pkg::PMC_INSTR_PDOWN);
    chk({15'h0000, refd}, 16'h0001);
    chk(16'(st), 16'h0000);
    nmi <= 1'b0;
    force_pd <= 1'b0;
    keep <= 1'b0;
    issue(pmc_pkg::PMC_INSTR_PDOWN);
    chk(16'(st), 16'h0002);
    chk(16'(cc), 16'h0001);
    rst_n_i <= 1'b0;
    tick();
    chk(16'(st), 16'h0000);
    chk(pdc, 16'h0000);
    end_of_test();
  end

  // Cut a hang short well inside the cycle budget.
  initial begin
    #40000;
    num_errors++;
    end_of_test();
  end
endmodule

// ### src/pmc_pkg.sv
/*
  Package of the power mode controller: power states, instruction codes,
  field widths and reset values shared by the design.
  Assumes nothing of its surroundings; it holds definitions only.
*/
package pmc_pkg;

  // ----------------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned PERIPH_N = 16;          // Peripheral modules governed.
  localparam int unsigned FREQ_W = 16;            // Width of the output reload.
  localparam logic [15:0] PERIPH_DIS_RST = 16'h0000; // All peripherals on.
  localparam logic [15:0] FREQ_RELOAD_RST = 16'h0000;
  localparam logic [15:0] FREQ_CNT_RST = 16'h0000;
  localparam logic [15:0] FREQ_ONE = 16'h0001;

  // ----------------------------------------------------------------------
  // Power state, Gray coded along normal -> idle -> sleep -> power-down
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PMC_RUN   = 2'b00,
    PMC_IDLE  = 2'b01,
    PMC_SLEEP = 2'b11,
    PMC_PDOWN = 2'b10
  } pmc_state_t;

  // Dedicated power instruction issued by the CPU core.
  typedef enum logic [1:0] {
    PMC_INSTR_NONE  = 2'b00,
    PMC_INSTR_IDLE  = 2'b01,
    PMC_INSTR_SLEEP = 2'b11,
    PMC_INSTR_PDOWN = 2'b10
  } pmc_instr_t;

  // Clock gate bundle driven toward the clock tree.
  typedef struct packed {
    logic cpu_en;       // CPU core clock enable.
    logic periph_en;    // Common peripheral clock enable.
    logic rtc_en;       // Real-time clock enable.
    logic sys_div2;     // High selects the 2:1 prescaler.
  } pmc_clk_t;

  localparam pmc_clk_t CLK_RST = '{cpu_en: 1'b1, periph_en: 1'b1,
                                   rtc_en: 1'b1, sys_div2: 1'b0};

endpackage

// ### src/pmc_power_mode_controller.sv
/*
  Power mode controller: power-saving state machine, clock gating,
  CPU clock prescaler, per-peripheral disable and programmable frequency
  output. Assumes the CPU core presents one-cycle instruction strobes and
  that all inputs are synchronous to clk_i.
*/
// What this block does
// - Power states entered only via dedicated instructions.
// - Idle stops CPU clock, peripherals keep running.
// - Sleep and power-down stop all clocks, RTC optional.
// - External interrupt ends sleep, clocks restart.
// - Inactive sections lose their clocks automatically.
// - Software may slow the CPU clock.
// - Frequency output rate programmable by software.
// - Each peripheral has its own disable bit.
// - RTC wake-up event ends a sleep phase.
// - System clock equals master clock or half.
`timescale 1ns/10ps
module pmc_power_mode_controller (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // CPU instruction port.
  input wire logic instr_valid_i,
  input wire pmc_pkg::pmc_instr_t instr_i,
  // Wake-up sources and the NMI pin.
  input wire logic irq_pending_i,
  input wire logic ext_irq_i,
  input wire logic rtc_wake_i,
  input wire logic nmi_pin_i,
  // Software configuration and peripheral activity.
  input wire logic rtc_keep_i,
  input wire logic cpu_div2_i,
  input wire logic [15:0] periph_dis_i,
  input wire logic periph_dis_we_i,
  input wire logic [15:0] freq_reload_i,
  input wire logic freq_we_i,
  input wire logic freq_run_i,
  input wire logic [15:0] periph_busy_i,
  // Status and clock controls.
  output pmc_pkg::pmc_state_t state_o,
  output pmc_pkg::pmc_clk_t clk_ctrl_o,
  output logic [15:0] periph_clk_en_o,
  output logic [15:0] peripheral_disable_ctrl_o,
  output logic programmable_freq_out_o,
  output logic pdown_refused_o
);

  // ----------------------------------------------------------------------
  // State register and next-state decode
  // ----------------------------------------------------------------------
  pmc_pkg::pmc_state_t state_q;
  pmc_pkg::pmc_state_t state_d;
  wire instr_idle = instr_valid_i && (instr_i == pmc_pkg::PMC_INSTR_IDLE);
  wire instr_sleep = instr_valid_i && (instr_i == pmc_pkg::PMC_INSTR_SLEEP);
  wire instr_pdown = instr_valid_i && (instr_i == pmc_pkg::PMC_INSTR_PDOWN);
  // Power-down is taken only with NMI low; otherwise it is refused.
  wire pdown_ok = instr_pdown && !nmi_pin_i;
  wire pdown_bad = instr_pdown && nmi_pin_i;

  // Next state; only instruction strobes leave the run state.
  always_comb begin
    state_d = state_q;
    case (state_q)
      pmc_pkg::PMC_RUN: begin
        if (instr_idle) begin
          state_d = pmc_pkg::PMC_IDLE;
        end else if (instr_sleep) begin
          state_d = pmc_pkg::PMC_SLEEP;
        end else if (pdown_ok) begin
          state_d = pmc_pkg::PMC_PDOWN;
        end
      end
      pmc_pkg::PMC_IDLE: begin
        // Any enabled interrupt resumes execution.
        if (irq_pending_i || ext_irq_i || rtc_wake_i) begin
          state_d = pmc_pkg::PMC_RUN;
        end
      end
      pmc_pkg::PMC_SLEEP: begin
        // External interrupt, or RTC wake-up with rtc_keep_i high, restarts the clocks.
        if (ext_irq_i || (rtc_wake_i && rtc_keep_i)) begin
          state_d = pmc_pkg::PMC_RUN;
        end
      end
      default: begin
        // Power-down is left by reset alone.
        state_d = pmc_pkg::PMC_PDOWN;
      end
    endcase
  end

  // Reset always lands in the run state.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= pmc_pkg::PMC_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------------
  // Clock gating decode
  // ----------------------------------------------------------------------
  wire run_st = (state_q == pmc_pkg::PMC_RUN);
  wire idle_st = (state_q == pmc_pkg::PMC_IDLE);
  // Decoded from the next state so the gates follow the state register.
  wire nrun = (state_d == pmc_pkg::PMC_RUN);
  wire nidle = (state_d == pmc_pkg::PMC_IDLE);
  pmc_pkg::pmc_clk_t clk_d;
  assign clk_d.cpu_en = nrun;
  assign clk_d.periph_en = nrun || nidle;
  assign clk_d.rtc_en = nrun || nidle || rtc_keep_i;
  assign clk_d.sys_div2 = cpu_div2_i;

  // Peripheral disable register; set bit stops that module.
  logic [15:0] pdis_q;
  wire [15:0] pdis_d = periph_dis_we_i ? periph_dis_i : pdis_q;
  // Busy-qualified gating: idle modules are clocked off with no software help.
  wire [15:0] pclk_d = (clk_d.periph_en ? ~pdis_d : pmc_pkg::PERIPH_DIS_RST)
                       & periph_busy_i;

  logic [15:0] pclk_q;
  pmc_pkg::pmc_clk_t clk_q;
  logic refused_q;

  // Gate registers; outputs come straight from these flip-flops.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pdis_q <= pmc_pkg::PERIPH_DIS_RST;
      pclk_q <= pmc_pkg::PERIPH_DIS_RST;
      clk_q <= pmc_pkg::CLK_RST;
      refused_q <= 1'b0;
    end else begin
      pdis_q <= pdis_d;
      pclk_q <= pclk_d;
      clk_q <= clk_d;
      refused_q <= pdown_bad && run_st;
    end
  end

  // ----------------------------------------------------------------------
  // Programmable frequency output
  // ----------------------------------------------------------------------
  // The pin toggles each time the counter runs out, so its period is
  // twice (reload + 1) clocks. A new reload takes effect at the next wrap,
  // which keeps the output free of runt pulses.
  logic [15:0] frel_q;
  logic [15:0] fcnt_q;
  logic freq_q;
  wire freq_go = freq_run_i && clk_d.periph_en;
  wire fwrap = (fcnt_q == pmc_pkg::FREQ_CNT_RST);
  wire [15:0] fcnt_d = !freq_go ? pmc_pkg::FREQ_CNT_RST :
                       fwrap ? frel_q : fcnt_q - pmc_pkg::FREQ_ONE;

  // Reload register and divider counter.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      frel_q <= pmc_pkg::FREQ_RELOAD_RST;
      fcnt_q <= pmc_pkg::FREQ_CNT_RST;
      freq_q <= 1'b0;
    end else begin
      frel_q <= freq_we_i ? freq_reload_i : frel_q;
      fcnt_q <= fcnt_d;
      freq_q <= freq_go ? (fwrap ? ~freq_q : freq_q) : 1'b0;
    end
  end

  assign state_o = state_q;
  assign clk_ctrl_o = clk_q;
  assign periph_clk_en_o = pclk_q;
  assign peripheral_disable_ctrl_o = pdis_q;
  assign programmable_freq_out_o = freq_q;
  assign pdown_refused_o = refused_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  run_only_instr_a: assert property (run_st && !instr_valid_i |=> run_st)
    else $error("Power state left without an instruction.");
  idle_gates_a: assert property (idle_st |-> !clk_q.cpu_en && clk_q.periph_en)
    else $error("Idle clock gating wrong.");
  sleep_gates_a: assert property (state_q inside {pmc_pkg::PMC_SLEEP, pmc_pkg::PMC_PDOWN}
    |-> !clk_q.cpu_en && !clk_q.periph_en && pclk_q == 16'h0000
        && (clk_q.rtc_en == $past(rtc_keep_i)))
    else $error("Sleep clock gating wrong.");
  sleep_wake_a: assert property ((state_q == pmc_pkg::PMC_SLEEP) && ext_irq_i
    |=> run_st && clk_q.cpu_en)
    else $error("Sleep not ended by external interrupt.");
  pdown_nmi_a: assert property (run_st && instr_pdown && nmi_pin_i
    |=> run_st && pdown_refused_o)
    else $error("Power-down taken with NMI high.");
  busy_gate_a: assert property (##1 (pclk_q & ~$past(periph_busy_i)) == 16'h0000)
    else $error("Inactive peripheral kept clocked.");
  div_sel_a: assert property (##1 clk_q.sys_div2 == $past(cpu_div2_i))
    else $error("Prescaler select not followed.");
  disable_bit_a: assert property (run_st && periph_dis_we_i
    |=> (pclk_q & $past(periph_dis_i)) == 16'h0000)
    else $error("Disabled peripheral kept clocked.");
  rtc_wake_a: assert property ((state_q == pmc_pkg::PMC_SLEEP) && rtc_wake_i && rtc_keep_i
    |=> run_st)
    else $error("RTC wake-up did not end sleep.");
  idle_exit_a: assert property (idle_st && irq_pending_i |=> run_st)
    else $error("Idle not left on interrupt.");
  // A half period loaded with two must hold the pin high for three edges.
  freq_period_a: assert property ($rose(freq_q) && fcnt_q == 16'h0002 && freq_go
    ##1 freq_go [*2] |-> freq_q ##1 !freq_q)
    else $error("Frequency output period wrong.");

  idle_trip_c: cover property (idle_st ##[1:20] run_st);
  sleep_trip_c: cover property ((state_q == pmc_pkg::PMC_SLEEP) ##[1:20] run_st);
  pdown_c: cover property (state_q == pmc_pkg::PMC_PDOWN);
  freq_c: cover property ($rose(freq_q) ##[1:40] $fell(freq_q));

endmodule
